// File: include/rsm_pkg.sv
package rsm_pkg;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [3:0] ADDR_INTEGRITY_CTRL_STATUS = 4'h0;
   localparam logic [3:0] ADDR_RESET_STATE = 4'h4;
   // integrity_ctrl_status fields
   localparam int BIT_AUX_SOURCE_SELECT = 7;
   localparam int BIT_AUX_IRQ_ENABLE = 6;
   localparam int BIT_AUX_LEVEL_FLAG = 5;
   localparam int BIT_LOW_SUPPLY_RESET_CAUSE = 4;
   localparam int BIT_WDG_RESET_CAUSE = 0;
   localparam logic [31:0] CTRL_RESET_VALUE = 32'h0000_0000;
   // ****************************************
   // sequence timing
   // ****************************************
   localparam int DELAY_SHORT_CYCLES = 256;
   localparam int DELAY_LONG_CYCLES = 4096;
   localparam int FETCH_CYCLES = 2;
   localparam logic [15:0] VECTOR_ADDR_HI = 16'hfffe;
   localparam logic [15:0] VECTOR_ADDR_LO = 16'hffff;
   localparam real PULSE_OUT_NS = 20.0;
   localparam real CLK_PERIOD_NS = 4.0;
   localparam int PULSE_OUT_CYCLES = int'($ceil(PULSE_OUT_NS / CLK_PERIOD_NS));
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   // reset phases, one-hot
   typedef enum logic [3:0]
   {
      RSM_ACTIVE = 4'h1,
      RSM_DELAY = 4'h2,
      RSM_FETCH = 4'h4,
      RSM_RUN = 4'h8
   } rsm_phase_e;
endpackage : rsm_pkg

// File: rtl/rsm_reset_phase_manager.sv
`timescale 1ns/100ps
module rsm_reset_phase_manager #(
   parameter int DELAY_LONG = rsm_pkg::DELAY_LONG_CYCLES, // long delay count
   parameter int PULSE_OUT = rsm_pkg::PULSE_OUT_CYCLES    // pin output width
)(
   input wire logic clk_sys_i,              // cpu clock
   input wire logic rst_i,                  // async reset, high
   input wire logic reset_pin_i,            // level of the shared reset pin
   output logic reset_pin_o,                // pin drive value, always low
   output logic reset_pin_oe_o,             // high while pulling the pin low
   input wire logic wdg_underflow_i,        // watchdog underflow pulse
   input wire logic low_supply_detector_i,  // comparator: supply below threshold
   input wire logic aux_main_cmp_i,         // aux comparator on main supply
   input wire logic external_monitor_input_i, // aux comparator on monitor pin
   input wire logic opt_lvd_enable_i,       // option: low supply detector on
   input wire logic [1:0] opt_lvd_level_i,  // option: low, medium, high threshold
   input wire logic opt_long_delay_i,       // option: 4096 cycle delay
   input wire logic opt_crystal_i,          // option: crystal oscillator chosen
   input wire logic irq_ack_i,              // cpu enters aux service routine
   output logic [1:0] lvd_level_o,          // threshold to analogue detectors
   output logic lvd_enable_o,               // enable to analogue detectors
   output logic osc_enable_o,               // main oscillator enable
   output logic cpu_reset_o,                // core held in reset
   output logic fetch_o,                    // vector fetch strobe
   output logic [15:0] fetch_addr_o,        // vector fetch address
   output logic aux_irq_o,                  // aux supply interrupt request
   input wire logic [3:0] s_axi_awaddr,     // write address
   input wire logic s_axi_awvalid,          // write address valid
   output logic s_axi_awready,              // write address ready
   input wire logic [31:0] s_axi_wdata,     // write data
   input wire logic [3:0] s_axi_wstrb,      // write strobes
   input wire logic s_axi_wvalid,           // write data valid
   output logic s_axi_wready,               // write data ready
   output logic [1:0] s_axi_bresp,          // write response
   output logic s_axi_bvalid,               // write response valid
   input wire logic s_axi_bready,           // write response ready
   input wire logic [3:0] s_axi_araddr,     // read address
   input wire logic s_axi_arvalid,          // read address valid
   output logic s_axi_arready,              // read address ready
   output logic [31:0] s_axi_rdata,         // read data
   output logic [1:0] s_axi_rresp,          // read response
   output logic s_axi_rvalid,               // read data valid
   input wire logic s_axi_rready            // read data ready
);
   // ****************************************
   // pin capture and synchroniser
   // ****************************************
   logic pin_low_async;
   logic pin_sync1;
   logic pin_sync2;
   logic pin_low_prev;
   logic [2:0] own_drive_hist;
   logic [12:0] stretch_cnt;
   logic [12:0] delay_cnt;
   logic [1:0] fetch_cnt;
   logic low_held;
   logic aux_sel;
   logic aux_ie;
   logic aux_flag;
   logic aux_flag_prev;
   logic aux_ie_prev;
   logic irq_pend;
   logic lvd_cause;
   logic wdg_cause;
   logic aux_armed;
   logic aw_hold;
   logic w_hold;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   rsm_pkg::rsm_phase_e phase;
   wire logic pin_low = ~reset_pin_i;
   wire logic lvd_low = opt_lvd_enable_i & low_supply_detector_i;
   // our own pull reaches the synchroniser up to three edges late, so hide it that long
   wire logic pin_ext = pin_sync2 & ~reset_pin_oe_o & ~(|own_drive_hist);
   wire logic pulse_start = pin_ext & ~pin_low_prev;
   // a source that demands the active phase; own pin drive is not a source
   wire logic src_any = lvd_low | wdg_underflow_i | pulse_start;
   wire logic stretching = (stretch_cnt != 13'h0000);
   wire logic do_write = aw_hold & w_hold & ~s_axi_bvalid;

   // asynchronous pin catch, released on the next clean clock edge
   always_ff @(posedge clk_sys_i or posedge pin_low or posedge rst_i)
   begin
      if (rst_i)
         pin_low_async <= 1'b0;
      else if (pin_low)
         pin_low_async <= 1'b1;
      else
         pin_low_async <= 1'b0;
   end

   // two flops before the sequencer sees the pin
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pin_sync1 <= 1'b0;
         pin_sync2 <= 1'b0;
         pin_low_prev <= 1'b0;
         own_drive_hist <= 3'h7;
      end
      else
      begin
         pin_sync1 <= pin_low_async;
         pin_sync2 <= pin_sync1;
         pin_low_prev <= pin_ext;
         own_drive_hist <= {own_drive_hist[1:0], reset_pin_oe_o};
      end
   end

   // ****************************************
   // pin drive stretch
   // ****************************************
   // stretch counts from recognition, so a long outside pulse outlives it
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         stretch_cnt <= 13'h0000;
      else if (pulse_start | wdg_underflow_i)
         stretch_cnt <= 13'(PULSE_OUT);
      else if (stretching)
         stretch_cnt <= stretch_cnt - 13'h0001;
   end

   // pin pulled low during active and delay phases and static low supply
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         reset_pin_oe_o <= 1'b1;
      else
         reset_pin_oe_o <= stretching | lvd_low | (phase == rsm_pkg::RSM_ACTIVE)
            | (phase == rsm_pkg::RSM_DELAY);
   end

   // ****************************************
   // phase sequencer
   // ****************************************
   // active holds while the pin is low, supply low or stretch runs
   assign low_held = lvd_low | pin_ext | stretching;

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         phase <= rsm_pkg::RSM_ACTIVE;
         delay_cnt <= 13'h0000;
         fetch_cnt <= 2'h0;
      end
      else if (src_any | low_held)
      begin
         phase <= rsm_pkg::RSM_ACTIVE;
      end
      else
      begin
         unique case (phase)
            rsm_pkg::RSM_ACTIVE:
            begin
               // count loaded on leaving active, so power-up also waits in full
               phase <= rsm_pkg::RSM_DELAY;
               delay_cnt <= opt_long_delay_i ? 13'(DELAY_LONG - 1)
                  : 13'(rsm_pkg::DELAY_SHORT_CYCLES - 1);
            end
            rsm_pkg::RSM_DELAY:
            begin
               if (delay_cnt == 13'h0000)
               begin
                  phase <= rsm_pkg::RSM_FETCH;
                  fetch_cnt <= 2'(rsm_pkg::FETCH_CYCLES - 1);
               end
               else
                  delay_cnt <= delay_cnt - 13'h0001;
            end
            rsm_pkg::RSM_FETCH:
            begin
               if (fetch_cnt == 2'h0)
                  phase <= rsm_pkg::RSM_RUN;
               else
                  fetch_cnt <= fetch_cnt - 2'h1;
            end
            rsm_pkg::RSM_RUN:
            begin
               phase <= rsm_pkg::RSM_RUN;
            end
         endcase
      end
   end

   // core reset, fetch strobe and vector address, same for every source
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cpu_reset_o <= 1'b1;
         fetch_o <= 1'b0;
         fetch_addr_o <= rsm_pkg::VECTOR_ADDR_HI;
      end
      else
      begin
         cpu_reset_o <= (phase != rsm_pkg::RSM_RUN);
         fetch_o <= (phase == rsm_pkg::RSM_FETCH);
         fetch_addr_o <= (fetch_cnt == 2'h0) ? rsm_pkg::VECTOR_ADDR_LO
            : rsm_pkg::VECTOR_ADDR_HI;
      end
   end

   // detector straps pass straight to the analogue side; oscillator enabled by the crystal strap or once the core runs
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         lvd_enable_o <= 1'b0;
         lvd_level_o <= 2'h0;
         osc_enable_o <= 1'b1;
         reset_pin_o <= 1'b0;
      end
      else
      begin
         lvd_enable_o <= opt_lvd_enable_i;
         lvd_level_o <= opt_lvd_level_i;
         osc_enable_o <= opt_crystal_i | ~cpu_reset_o;
         reset_pin_o <= 1'b0;
      end
   end

   // ****************************************
   // aux supply detector
   // ****************************************
   // flag follows the selected comparator; forced clear with detector off
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         aux_flag <= 1'b0;
      else if (!opt_lvd_enable_i)
         aux_flag <= 1'b0;
      else
         aux_flag <= aux_sel ? external_monitor_input_i : aux_main_cmp_i;
   end

   // toggles only count once the core runs, hiding crossings inside the delay
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         aux_flag_prev <= 1'b0;
         aux_ie_prev <= 1'b0;
         aux_armed <= 1'b0;
      end
      else
      begin
         aux_flag_prev <= aux_flag;
         aux_ie_prev <= aux_ie;
         aux_armed <= (phase == rsm_pkg::RSM_RUN);
      end
   end

   // set wins over acknowledge
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         irq_pend <= 1'b0;
      else if (aux_armed & aux_ie & opt_lvd_enable_i
         & ((aux_flag != aux_flag_prev) | (aux_flag & ~aux_ie_prev)))
         irq_pend <= 1'b1;
      else if (irq_ack_i)
         irq_pend <= 1'b0;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         aux_irq_o <= 1'b0;
      else
         aux_irq_o <= irq_pend & aux_ie;
   end

   // ****************************************
   // control register and cause flags
   // ****************************************
   // low supply reset is sticky; set wins over a software zero write
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         aux_sel <= 1'b0;
         aux_ie <= 1'b0;
         lvd_cause <= 1'b0;
         wdg_cause <= 1'b0;
      end
      else
      begin
         if (do_write && aw_addr == rsm_pkg::ADDR_INTEGRITY_CTRL_STATUS && w_strb[0])
         begin
            aux_sel <= w_data[rsm_pkg::BIT_AUX_SOURCE_SELECT];
            aux_ie <= w_data[rsm_pkg::BIT_AUX_IRQ_ENABLE];
            if (!w_data[rsm_pkg::BIT_LOW_SUPPLY_RESET_CAUSE])
               lvd_cause <= 1'b0;
            if (!w_data[rsm_pkg::BIT_WDG_RESET_CAUSE])
               wdg_cause <= 1'b0;
         end
         if (lvd_low)
         begin
            lvd_cause <= 1'b1;
            wdg_cause <= 1'b0;
         end
         else if (wdg_underflow_i)
            wdg_cause <= 1'b1;
      end
   end

   // ****************************************
   // axi4-lite slave
   // ****************************************
   // write address and data taken in either order, then one response
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= rsm_pkg::AXI_OKAY;
      end
      else
      begin
         s_axi_awready <= ~aw_hold & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_hold & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awready & s_axi_awvalid)
         begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wready & s_axi_wvalid)
         begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == rsm_pkg::ADDR_INTEGRITY_CTRL_STATUS)
               ? rsm_pkg::AXI_OKAY : rsm_pkg::AXI_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // read path, one cycle from address to data
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= rsm_pkg::CTRL_RESET_VALUE;
         s_axi_rresp <= rsm_pkg::AXI_OKAY;
      end
      else
      begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arready & s_axi_arvalid)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rsm_pkg::AXI_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if (s_axi_araddr == rsm_pkg::ADDR_INTEGRITY_CTRL_STATUS)
            begin
               s_axi_rdata[rsm_pkg::BIT_AUX_SOURCE_SELECT] <= aux_sel;
               s_axi_rdata[rsm_pkg::BIT_AUX_IRQ_ENABLE] <= aux_ie;
               s_axi_rdata[rsm_pkg::BIT_AUX_LEVEL_FLAG] <= aux_flag;
               s_axi_rdata[rsm_pkg::BIT_LOW_SUPPLY_RESET_CAUSE] <= lvd_cause;
               s_axi_rdata[rsm_pkg::BIT_WDG_RESET_CAUSE] <= wdg_cause;
            end
            else if (s_axi_araddr == rsm_pkg::ADDR_RESET_STATE)
               s_axi_rdata[3:0] <= phase;
            else
               s_axi_rresp <= rsm_pkg::AXI_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule : rsm_reset_phase_manager

// File: tb/rsm_reset_phase_manager_properties.sv
`timescale 1ns/100ps
// ****************************************
// reset sequence and supply checker
// ****************************************
module rsm_reset_phase_manager_props #(
   parameter int PULSE_OUT = 5 // shortest pin pull in cycles
)(
   input wire logic clk_sys_i,                // cpu clock
   input wire logic rst_i,                    // async reset, high
   input wire logic reset_pin_oe_o,           // device pulls pin low
   input wire logic wdg_underflow_i,          // watchdog underflow
   input wire logic low_supply_detector_i,    // supply below threshold
   input wire logic lvd_enable_o,             // detector enable copy
   input wire logic opt_crystal_i,            // crystal strap
   input wire logic osc_enable_o,             // oscillator enable
   input wire logic cpu_reset_o,              // core held in reset
   input wire logic fetch_o,                  // vector fetch strobe
   input wire logic [15:0] fetch_addr_o,      // vector fetch address
   input wire logic aux_irq_o,                // aux request
   input wire logic irq_ack_i,                // service routine entry
   input wire logic aux_main_cmp_i,           // aux comparator, main supply
   input wire logic external_monitor_input_i  // aux comparator, monitor pin
);
   int oe_run;
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   // length of the current pull, so a short stretch shows at its end
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         oe_run <= 0;
      else if (reset_pin_oe_o)
         oe_run <= oe_run + 1;
      else
         oe_run <= 0;
   end
   // the comparators must settle first, else a late toggle re-arms the request
   sequence aux_quiet_s;
      ($stable(aux_main_cmp_i) && $stable(external_monitor_input_i))[*4];
   endsequence
   fetch_width_a: assert property ($rose(fetch_o) |=> fetch_o ##1 !fetch_o)
      else $error("fetch strobe not two cycles wide");
   vector_addr_a: assert property ($rose(fetch_o) |-> fetch_addr_o == 16'hfffe
      ##1 fetch_addr_o == 16'hffff) else $error("wrong vector address");
   delay_pin_a: assert property ($rose(fetch_o) |-> $past(reset_pin_oe_o))
      else $error("pin released before delay end");
   fetch_core_a: assert property (fetch_o |-> cpu_reset_o)
      else $error("fetch outside reset");
   release_order_a: assert property ($fell(cpu_reset_o) |-> $past(fetch_o)
      || $past(fetch_o, 2)) else $error("core released without fetch");
   supply_hold_a: assert property (lvd_enable_o && low_supply_detector_i
      |-> ##[1:4] (reset_pin_oe_o && cpu_reset_o)) else $error("low supply not held");
   wdg_pull_a: assert property (wdg_underflow_i && !cpu_reset_o
      |-> ##[1:4] reset_pin_oe_o) else $error("watchdog did not pull pin");
   pull_width_a: assert property ($fell(reset_pin_oe_o) |-> oe_run >= PULSE_OUT)
      else $error("pin pull too short");
   osc_run_a: assert property ($past(opt_crystal_i) |-> osc_enable_o)
      else $error("crystal stopped in reset");
   ack_clear_a: assert property (aux_quiet_s ##0 (irq_ack_i && aux_irq_o)
      |-> ##2 !aux_irq_o) else $error("request not cleared by entry");
   cover property ($rose(fetch_o));
   cover property ($rose(aux_irq_o));
   cover property (wdg_underflow_i && !cpu_reset_o);
endmodule : rsm_reset_phase_manager_props

bind rsm_reset_phase_manager rsm_reset_phase_manager_props #(.PULSE_OUT(PULSE_OUT))
   u_rsm_reset_phase_manager_props (.clk_sys_i, .rst_i, .reset_pin_oe_o, .wdg_underflow_i,
   .low_supply_detector_i, .lvd_enable_o, .opt_crystal_i, .osc_enable_o, .cpu_reset_o,
   .fetch_o, .fetch_addr_o, .aux_irq_o, .irq_ack_i, .aux_main_cmp_i,
   .external_monitor_input_i);

// File: tb/rsm_ext_reset.sv
`timescale 1ns/100ps
// ****************************************
// outside reset circuit on the shared pin
// ****************************************
module rsm_ext_reset #(
   parameter int MIN_LOW = 4 // shortest pulse it will give
)(
   input wire logic clk_sys_i,    // cpu clock
   input wire logic dev_oe_i,     // device pulls pin low
   input wire logic [7:0] hold_i, // requested low time
   input wire logic go_i,         // start a pulse
   output logic pin_o             // resolved pin level
);
   int left = 0;
   // pull-up idles high, either party may pull low
   assign pin_o = !(dev_oe_i || left > 0);
   // short requests are widened so the device can recognise them
   always @(posedge clk_sys_i)
   begin
      if (go_i)
         left <= (int'(hold_i) < MIN_LOW) ? MIN_LOW : int'(hold_i);
      else if (left > 0)
         left <= left - 1;
   end
endmodule : rsm_ext_reset

// File: tb/rsm_reset_phase_manager_tb.sv
`timescale 1ns/100ps
module rsm_reset_phase_manager_tb;
   localparam int DLONG = 64;
   localparam int PW = 5;
   logic clk_sys_i, rst_i, wdg_underflow_i, low_supply_detector_i, aux_main_cmp_i, go;
   logic external_monitor_input_i, opt_lvd_enable_i, opt_long_delay_i, irq_ack_i;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic reset_pin_i, reset_pin_oe_o, cpu_reset_o, fetch_o, aux_irq_o, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [3:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [15:0] fetch_addr_o;
   logic [7:0] hold;
   logic [15:0] fq[$];
   int mismatches = 0, cmp_count = 0, cycles = 0, oe_cnt = 0, oe_len = 0, n;
   rsm_reset_phase_manager #(.DELAY_LONG(DLONG), .PULSE_OUT(PW)) u_rsm_reset_phase_manager (
      .clk_sys_i, .rst_i, .reset_pin_i, .reset_pin_o(), .reset_pin_oe_o, .wdg_underflow_i,
      .low_supply_detector_i, .aux_main_cmp_i, .external_monitor_input_i, .opt_lvd_enable_i,
      .opt_lvd_level_i(2'h1), .opt_long_delay_i, .opt_crystal_i(1'b1), .irq_ack_i,
      .lvd_level_o(), .lvd_enable_o(), .osc_enable_o(), .cpu_reset_o, .fetch_o, .fetch_addr_o,
      .aux_irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   rsm_ext_reset u_rsm_ext_reset (.clk_sys_i, .dev_oe_i(reset_pin_oe_o), .hold_i(hold),
      .go_i(go), .pin_o(reset_pin_i));
   initial
   begin
      clk_sys_i = 0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   // watch on the falling edge, where registered outputs have settled
   always @(negedge clk_sys_i)
   begin
      if (fetch_o)
         fq.push_back(fetch_addr_o);
      if (reset_pin_oe_o)
         oe_cnt++;
      else if (oe_cnt > 0)
      begin
         oe_len = oe_cnt;
         oe_cnt = 0;
      end
      cycles++;
      if (cycles > 40000)
      begin
         mismatches++;
         give_verdict();
      end
   end
   task give_verdict;
      $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task chk_rng(input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h..%h", $time, got, lo, hi);
      end
   endtask : chk_rng
   task step(input int k);
      repeat (k) @(negedge clk_sys_i);
   endtask : step
   task done(input string s);
      $display("test %s ends, mismatches so far %0d", s, mismatches);
   endtask : done
   // handshakes are judged at the falling edge and released on the next rising one
   task axi_wr(input logic [3:0] a, input logic [31:0] d);
      logic aw_t, w_t, b_t;
      b_t = 0;
      @(posedge clk_sys_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!b_t)
      begin
         @(negedge clk_sys_i);
         aw_t = s_axi_awvalid && s_axi_awready;
         w_t = s_axi_wvalid && s_axi_wready;
         b_t = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge clk_sys_i);
         if (aw_t)
            s_axi_awvalid <= 0;
         if (w_t)
            s_axi_wvalid <= 0;
         if (b_t)
            s_axi_bready <= 0;
      end
   endtask : axi_wr
   task axi_rd(input logic [3:0] a);
      logic ar_t, r_t;
      r_t = 0;
      @(posedge clk_sys_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      while (!r_t)
      begin
         @(negedge clk_sys_i);
         ar_t = s_axi_arvalid && s_axi_arready;
         r_t = s_axi_rvalid;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge clk_sys_i);
         if (ar_t)
            s_axi_arvalid <= 0;
         if (r_t)
            s_axi_rready <= 0;
      end
   endtask : axi_rd
   // time to core release, then the two vector fetches
   task run_check(input int d);
      logic seen;
      seen = 0;
      n = 0;
      fq.delete();
      while (!(seen && cpu_reset_o === 1'b0))
      begin
         @(negedge clk_sys_i);
         n++;
         if (cpu_reset_o === 1'b1)
            seen = 1;
      end
      chk_rng(n, d, d + 40);
      chk(fq.size(), 2);
      chk({fq[0], fq[1]}, 32'hfffe_ffff);
   endtask : run_check
   task wdg_pulse;
      @(posedge clk_sys_i);
      wdg_underflow_i <= 1;
      @(posedge clk_sys_i);
      wdg_underflow_i <= 0;
   endtask : wdg_pulse
   task ack_irq;
      @(posedge clk_sys_i);
      irq_ack_i <= 1;
      @(posedge clk_sys_i);
      irq_ack_i <= 0;
   endtask : ack_irq
   initial
   begin
      {rst_i, opt_lvd_enable_i} = 2'h3;
      {wdg_underflow_i, low_supply_detector_i, aux_main_cmp_i, go, irq_ack_i} = 5'h0;
      {external_monitor_input_i, opt_long_delay_i, hold} = 10'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 0;
      run_check(256);
      axi_rd(4'h0);
      chk(rd, 32'h0);
      axi_rd(4'h4);
      chk(rd, 32'h8);
      axi_rd(4'h8);
      chk(rs, rsm_pkg::AXI_SLVERR);
      done("power_up");
      @(posedge clk_sys_i);
      {opt_long_delay_i, rst_i} <= 2'h3;
      @(posedge clk_sys_i);
      rst_i <= 0;
      run_check(DLONG);
      opt_long_delay_i <= 0;
      done("long_delay");
      @(posedge clk_sys_i);
      {hold, go} <= {8'h3, 1'b1};
      @(posedge clk_sys_i);
      go <= 0;
      run_check(256);
      chk_rng(oe_len, 256, 400);
      axi_rd(4'h0);
      chk(rd[4:0], 5'h0);
      done("pin_pulse");
      @(posedge clk_sys_i);
      low_supply_detector_i <= 1;
      step(60);
      chk({reset_pin_i, cpu_reset_o}, 2'h1);
      @(posedge clk_sys_i);
      low_supply_detector_i <= 0;
      run_check(256);
      wdg_pulse();
      run_check(256);
      axi_rd(4'h0);
      chk(rd[4:0], 5'h11);
      axi_wr(4'h0, 32'h0);
      axi_rd(4'h0);
      chk(rd[4:0], 5'h0);
      done("supply_and_watchdog");
      wdg_pulse();
      step(100);
      wdg_pulse();
      run_check(256);
      done("restart");
      axi_wr(4'h0, 32'h40);
      @(posedge clk_sys_i);
      aux_main_cmp_i <= 1;
      step(8);
      chk(aux_irq_o, 1);
      axi_rd(4'h0);
      chk(rd[7:5], 3'h3);
      ack_irq();
      step(2);
      chk(aux_irq_o, 0);
      @(posedge clk_sys_i);
      aux_main_cmp_i <= 0;
      step(8);
      chk(aux_irq_o, 1);
      ack_irq();
      axi_wr(4'h0, 32'hc0);
      @(posedge clk_sys_i);
      aux_main_cmp_i <= 1;
      step(8);
      chk(aux_irq_o, 0);
      @(posedge clk_sys_i);
      external_monitor_input_i <= 1;
      step(8);
      axi_rd(4'h0);
      chk({aux_irq_o, rd[5]}, 2'h3);
      ack_irq();
      axi_wr(4'h0, 32'h80);
      axi_wr(4'h0, 32'hc0);
      step(4);
      chk(aux_irq_o, 1);
      ack_irq();
      wdg_pulse();
      step(20);
      @(posedge clk_sys_i);
      external_monitor_input_i <= 0;
      step(300);
      chk(aux_irq_o, 0);
      @(posedge clk_sys_i);
      opt_lvd_enable_i <= 0;
      step(4);
      @(posedge clk_sys_i);
      external_monitor_input_i <= 1;
      step(8);
      chk(aux_irq_o, 0);
      done("aux_detector");
      give_verdict();
   end
endmodule : rsm_reset_phase_manager_tb
